// ---- design/poc_pkg.sv ----
// constants, types and the register map of the receive path overhead capture
// assumes a single 100 MHz ref_clk domain for all users of the package
package poc_pkg;

  localparam logic [7:0] OFS_RX_G1      = 8'h7A;
  localparam logic [7:0] OFS_RX_F2      = 8'h7B;
  localparam logic [7:0] OFS_RX_H4      = 8'h7C;
  localparam logic [7:0] OFS_RX_Z3      = 8'h7D;
  localparam logic [7:0] OFS_RX_Z4      = 8'h7E;
  localparam logic [7:0] OFS_RX_Z5      = 8'h7F;
  localparam logic [7:0] OFS_RX_TRACE   = 8'hC0;
  localparam logic [7:0] OFS_EXP_TRACE  = 8'hF0;

  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] G1_USED_MASK   = 8'hF8;
  localparam int         OH_REGS        = 6;
  localparam int         TRACE_LONG     = 64;
  localparam int         TRACE_SHORT    = 16;
  localparam logic [5:0] PTR_MASK_LONG  = 6'h3F;
  localparam logic [5:0] PTR_MASK_SHORT = 6'h0F;
  localparam logic [3:0] MF_LAST        = 4'hF;
  // clean multiframes in a row before the message counts as stable
  localparam logic [1:0] STABLE_MF      = 2'h3;

  typedef enum logic [2:0] {
    KIND_J1 = 3'h0,
    KIND_G1 = 3'h1,
    KIND_F2 = 3'h2,
    KIND_H4 = 3'h3,
    KIND_Z3 = 3'h4,
    KIND_Z4 = 3'h5,
    KIND_Z5 = 3'h6
  } pocKind_e;

  typedef enum logic [1:0] {
    ST_SEARCH = 2'b01,
    ST_LOCKED = 2'b10
  } pocLock_e;

  typedef struct packed {
    logic       valid;
    pocKind_e   kind;
    logic [7:0] data;
  } pocPoh_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pocCpuReq_s;

endpackage : poc_pkg

// ---- design/poc_rx_path_overhead_capture.sv ----
// receive path overhead capture: per-frame overhead bytes and trace buffer
// assumes drop-bus bytes and cpu strobes come from logic on ref_clk;
// the overhead enable pin is asynchronous and gets synchronised here
`timescale 1ns/1ns
`default_nettype none

// Contract
// RULE_01: each frame's received F2 byte overwrites a read-only location.
// RULE_02: each frame's received H4 byte overwrites its own read-only location.
// RULE_03: Z3, Z4, Z5 each go to consecutive read-only locations every frame.
// RULE_04: first transmitted bit of a byte lands in register bit 7.
// RULE_05: G1 register: FEBE in bits 7..4, RDI in bit 3, rest unassigned.
// RULE_06: length select 1 keeps a 16-byte trace at the segment base.
// RULE_07: length select 0 uses the whole segment as a 64-byte buffer.
// RULE_08: unaligned, each trace byte goes to the next location, wrapping.
// RULE_09: aligned and locked, the multiframe-start byte sits at the base.
// RULE_10: aligned mode shows only the debounced stable message.
// RULE_11: software writes expected 16-byte message before enabling compare.
// RULE_12: received trace is compared against the expected message.
// RULE_13: expected message's multiframe-start byte sits at compare base.
// RULE_14: the block aligns incoming trace itself before comparing.
// RULE_15: overhead processing runs only while the enable pin is high.
// RULE_16: trace mismatch and loss of lock are readable status flags.
module poc_rx_path_overhead_capture
  (
  input  wire logic               ref_clk,            // 100 MHz clock
  input  wire logic               rst_n,              // async reset, low
  input  wire logic               overheadProcessingEnablePin, // async pin
  input  wire logic               traceLengthSelect,  // 1: 16-byte trace
  input  wire logic               traceCompareEnable, // 1 with 16-byte length: align, compare
  input  wire poc_pkg::pocPoh_s   pohIn,              // drop bus poh byte
  input  wire poc_pkg::pocCpuReq_s cpuReq,            // cpu read/write
  output logic [7:0]              cpuRdData,          // read data, +1 cycle
  output logic                    traceLossOfLock,    // trace not stable
  output logic                    traceMismatch       // stable != expected
  );
  import poc_pkg::*;

  logic [1:0]  rstSync;
  logic        rstInt;
  logic [2:0]  enSync;
  logic        enOk;
  logic        next_enOk;

  logic [7:0]  ohReg  [OH_REGS];
  logic [7:0]  rxBuf  [TRACE_LONG];
  logic [7:0]  expBuf [TRACE_SHORT];
  logic [7:0]  cand   [TRACE_SHORT];

  logic [5:0]  rotPtr;
  logic [5:0]  next_rotPtr;
  logic [3:0]  mfIdx;
  logic [3:0]  next_mfIdx;
  logic        mfBad;
  logic        next_mfBad;
  logic [1:0]  stableCnt;
  logic [1:0]  next_stableCnt;
  pocLock_e    lockState;
  pocLock_e    next_lockState;
  logic        next_traceLossOfLock;
  logic        next_traceMismatch;
  logic [7:0]  next_cpuRdData;

  logic        pohTake;
  logic        j1Take;
  logic        alignedMode;
  logic        mfStart;
  logic        posOk;
  logic [3:0]  byteIdx;
  logic        badNow;
  logic        mfEnd;
  logic        copyStable;
  logic        ohWrite;
  logic [2:0]  ohIdx;
  logic [7:0]  ohData;
  logic        rotWrite;
  logic        expWrite;

  // true when the candidate message, with its last byte, equals the expected
  function automatic logic msgEqual(input logic [7:0] lastByte);
    logic eq;
    eq = (lastByte == expBuf[MF_LAST]);
    for (int i = 0; i < TRACE_SHORT - 1; i++)
    begin
      if (cand[i] != expBuf[i])
      begin
        eq = 1'b0;
      end
    end
    return eq;
  endfunction : msgEqual

  assign rstInt = rstSync[1];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync <= 2'h0;
    end
    else
    begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  // pin change accepted only once stages two and three agree
  always_comb
  begin
    next_enOk = enOk;
    if (enSync[1] == enSync[2])
    begin
      next_enOk = enSync[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstInt)
  begin
    if (!rstInt)
    begin
      enSync <= 3'h0;
      enOk   <= 1'b0;
    end
    else
    begin
      enSync <= {enSync[1:0], overheadProcessingEnablePin};
      enOk   <= next_enOk;
    end
  end

  always_comb
  begin
    pohTake     = pohIn.valid && enOk;                   // see RULE_15
    j1Take      = pohTake && (pohIn.kind == KIND_J1);
    alignedMode = traceLengthSelect && traceCompareEnable;
    mfStart     = pohIn.data[7];
    byteIdx     = mfStart ? 4'h0 : mfIdx + 4'h1;         // see RULE_14
    posOk       = (mfStart == (mfIdx == MF_LAST));
    badNow      = !posOk || (pohIn.data != cand[byteIdx]);
    if (byteIdx != 4'h0)
    begin
      badNow = badNow || mfBad;
    end
    mfEnd       = j1Take && (byteIdx == MF_LAST);

    next_mfIdx     = j1Take ? byteIdx : mfIdx;
    next_mfBad     = mfBad;
    next_stableCnt = stableCnt;
    next_lockState = lockState;
    copyStable     = 1'b0;
    if (j1Take)
    begin
      next_mfBad = mfEnd ? 1'b0 : badNow;
    end
    // a message must repeat unchanged and aligned before it is trusted
    if (mfEnd)
    begin
      if (badNow)
      begin
        next_stableCnt = 2'h0;
        next_lockState = ST_SEARCH;
      end
      else
      begin
        if (stableCnt != STABLE_MF)
        begin
          next_stableCnt = stableCnt + 2'h1;
        end
        // compare without a 2-bit sum, which wraps once locked
        if (stableCnt >= STABLE_MF - 2'h1)
        begin
          next_lockState = ST_LOCKED;
          copyStable     = 1'b1;                         // see RULE_10
        end
      end
    end

    next_traceLossOfLock = (next_lockState != ST_LOCKED); // see RULE_16
    next_traceMismatch   = traceMismatch;
    if (!alignedMode)
    begin
      next_traceMismatch = 1'b0;
    end
    else if (copyStable)
    begin
      next_traceMismatch = !msgEqual(pohIn.data);         // see RULE_12
    end

    // unaligned capture rotates through 16 or 64 locations
    rotWrite    = j1Take && !alignedMode;                 // see RULE_08
    next_rotPtr = rotPtr;
    if (rotWrite)
    begin
      next_rotPtr = (rotPtr + 6'h1) & (traceLengthSelect ? PTR_MASK_SHORT
                                                         : PTR_MASK_LONG);
    end
    else if (rotPtr > (traceLengthSelect ? PTR_MASK_SHORT : PTR_MASK_LONG))
    begin
      next_rotPtr = 6'h0;                                 // see RULE_06
    end

    // bytes stored as received: bit 7 is the first bit on the wire
    ohWrite = pohTake && (pohIn.kind != KIND_J1);         // see RULE_04
    ohIdx   = 3'(pohIn.kind) - 3'h1;
    ohData  = pohIn.data;
    if (pohIn.kind == KIND_G1)
    begin
      ohData = pohIn.data & G1_USED_MASK;                 // see RULE_05
    end

    expWrite = cpuReq.wr && (cpuReq.addr >= OFS_EXP_TRACE); // see RULE_13

    next_cpuRdData = cpuRdData;
    if (cpuReq.rd)
    begin
      next_cpuRdData = 8'h00;
      if (cpuReq.addr >= OFS_RX_G1 && cpuReq.addr <= OFS_RX_Z5)
      begin
        next_cpuRdData = ohReg[3'(cpuReq.addr - OFS_RX_G1)];
      end
      else if (cpuReq.addr >= OFS_EXP_TRACE && traceLengthSelect)
      begin
        next_cpuRdData = expBuf[cpuReq.addr[3:0]];
      end
      else if (cpuReq.addr >= OFS_RX_TRACE)
      begin
        next_cpuRdData = rxBuf[cpuReq.addr[5:0]];         // see RULE_07
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstInt)
  begin
    if (!rstInt)
    begin
      rotPtr          <= 6'h0;
      mfIdx           <= MF_LAST;
      mfBad           <= 1'b1;
      stableCnt       <= 2'h0;
      lockState       <= ST_SEARCH;
      traceLossOfLock <= 1'b1;
      traceMismatch   <= 1'b0;
      cpuRdData       <= RST_BYTE;
      for (int i = 0; i < OH_REGS; i++)
      begin
        ohReg[i] <= RST_BYTE;
      end
    end
    else
    begin
      rotPtr          <= next_rotPtr;
      mfIdx           <= next_mfIdx;
      mfBad           <= next_mfBad;
      stableCnt       <= next_stableCnt;
      lockState       <= next_lockState;
      traceLossOfLock <= next_traceLossOfLock;
      traceMismatch   <= next_traceMismatch;
      cpuRdData       <= next_cpuRdData;
      if (ohWrite)
      begin
        ohReg[ohIdx] <= ohData;                // see RULE_01 RULE_02 RULE_03
      end
    end
  end

  // memories carry no reset; their content is undefined until written
  always_ff @(posedge ref_clk)
  begin
    if (j1Take)
    begin
      cand[byteIdx] <= pohIn.data;
    end
    if (rotWrite)
    begin
      rxBuf[rotPtr] <= pohIn.data;
    end
    else if (alignedMode && copyStable)                   // see RULE_09
    begin
      for (int i = 0; i < TRACE_SHORT; i++)
      begin
        rxBuf[i] <= (i == TRACE_SHORT - 1) ? pohIn.data : cand[i];
      end
    end
    if (expWrite)
    begin
      expBuf[cpuReq.addr[3:0]] <= cpuReq.wdata;           // see RULE_11
    end
  end

endmodule : poc_rx_path_overhead_capture

`default_nettype wire

// ---- sim/poc_rx_path_overhead_capture_asserts.sv ----
// port checker for the receive path overhead capture
// assumes binding onto poc_rx_path_overhead_capture, one clock
`timescale 1ns/1ns
`default_nettype none
module poc_rx_path_overhead_capture_asserts
  (
  input wire logic                ref_clk,   // clock
  input wire logic                rst_n,     // reset, low
  input wire logic                overheadProcessingEnablePin, // pin
  input wire logic                traceLengthSelect,  // 16-byte
  input wire logic                traceCompareEnable, // align
  input wire poc_pkg::pocPoh_s    pohIn,     // drop byte
  input wire poc_pkg::pocCpuReq_s cpuReq,    // cpu access
  input wire logic [7:0]          cpuRdData, // read data
  input wire logic                traceLossOfLock, // no lock
  input wire logic                traceMismatch    // differs
  );
  import poc_pkg::*;
  logic [2:0] upCnt;
  logic [6:0] j1Cnt;
  logic [7:0] sh [8];
  logic [7:0] hist [16];
  // a byte counts only once the pin has settled through its synchroniser
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      upCnt <= 3'h0;
      j1Cnt <= 7'h00;
      sh <= '{default: 8'h00};
      hist <= '{default: 8'h00};
    end
    else
    begin
      upCnt <= !overheadProcessingEnablePin ? 3'h0
             : upCnt + 3'(upCnt != 3'h7);
      if (pohIn.valid && upCnt > 3'h4)
        sh[pohIn.kind] <= pohIn.data;
      // run of trace bytes equal to the byte one multiframe earlier
      if (pohIn.valid && upCnt > 3'h4 && pohIn.kind == KIND_J1)
      begin
        for (int i = 15; i > 0; i--)
          hist[i] <= hist[i - 1];
        hist[0] <= pohIn.data;
        j1Cnt <= (pohIn.data != hist[15]) ? 7'h00
               : j1Cnt + 7'(j1Cnt != 7'h7F);
      end
    end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ohRead;
    cpuReq.rd && cpuReq.addr inside {[8'h7B:8'h7F]}
      |=> cpuRdData == $past(sh[3'(cpuReq.addr - 8'h79)]);
  endproperty
  a_ohRead: assert property (p_ohRead)
    else $error("overhead read wrong");
  property p_g1Read;
    cpuReq.rd && cpuReq.addr == OFS_RX_G1
      |=> cpuRdData == ($past(sh[1]) & G1_USED_MASK);
  endproperty
  a_g1Read: assert property (p_g1Read)
    else $error("g1 read wrong");
  property p_hold;
    !cpuReq.rd |=> $stable(cpuRdData);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved");
  property p_misOff;
    !(traceLengthSelect && traceCompareEnable) [*2] |-> !traceMismatch;
  endproperty
  a_misOff: assert property (p_misOff)
    else $error("mismatch outside aligned mode");
  property p_misMode;
    $rose(traceMismatch) |-> $past(traceLengthSelect && traceCompareEnable);
  endproperty
  a_misMode: assert property (p_misMode)
    else $error("mismatch rose unaligned");
  property p_misLock;
    $rose(traceMismatch) |-> !traceLossOfLock;
  endproperty
  a_misLock: assert property (p_misLock)
    else $error("mismatch without lock");
  property p_lolRst;
    $rose(rst_n) |-> traceLossOfLock && !traceMismatch;
  endproperty
  a_lolRst: assert property (p_lolRst)
    else $error("flags wrong at reset");
  property p_lolCnt;
    $fell(traceLossOfLock) |-> j1Cnt >= 7'd48;
  endproperty
  a_lolCnt: assert property (p_lolCnt)
    else $error("lock before three multiframes");
endmodule : poc_rx_path_overhead_capture_asserts
bind poc_rx_path_overhead_capture poc_rx_path_overhead_capture_asserts
  poc_rx_path_overhead_capture_asserts_i (.ref_clk, .rst_n,
  .overheadProcessingEnablePin, .traceLengthSelect, .traceCompareEnable,
  .pohIn, .cpuReq, .cpuRdData, .traceLossOfLock, .traceMismatch);
`default_nettype wire

// ---- sim/poc_drop_model.sv ----
// drop bus model: one path overhead byte per send call
// assumes a single calling process; bytes go out every other cycle
`timescale 1ns/1ns
`default_nettype none
module poc_drop_model
  (
  input  wire logic           ref_clk, // clock
  output var poc_pkg::pocPoh_s pohOut  // drop byte
  );
  import poc_pkg::*;
  initial pohOut = '0;
  task automatic send(input pocKind_e k, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    pohOut = {1'b1, k, d};
    @(posedge ref_clk);
    #1;
    // released data is garbage, never the last byte
    pohOut = {1'b0, k, ~d};
  endtask : send
endmodule : poc_drop_model
`default_nettype wire

// ---- sim/poc_rx_path_overhead_capture_test.sv ----
// self-checking bench for the receive path overhead capture
// assumes poc_drop_model and the bound port checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    nCompared++; \
    if ((g) !== (e)) \
    begin \
      errTotal++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module poc_rx_path_overhead_capture_test;
  import poc_pkg::*;
  logic       ref_clk;
  logic       rst_n;
  logic       enPin;
  logic       lenSel;
  logic       cmpEn;
  pocPoh_s    poh;
  pocCpuReq_s req;
  logic [7:0] rdData;
  logic       lol;
  logic       mis;
  int         errTotal;
  int         nCompared;
  int         ptr;
  logic [7:0] msg [16];
  always #5 ref_clk = ~ref_clk;
  poc_drop_model poc_drop_model_i (.ref_clk(ref_clk), .pohOut(poh));
  poc_rx_path_overhead_capture poc_rx_path_overhead_capture_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .overheadProcessingEnablePin(enPin),
    .traceLengthSelect(lenSel), .traceCompareEnable(cmpEn), .pohIn(poh),
    .cpuReq(req), .cpuRdData(rdData), .traceLossOfLock(lol),
    .traceMismatch(mis));
  task automatic cpu(input logic r, input logic [7:0] a, d);
    @(posedge ref_clk);
    #1;
    req = {r, !r, a, d};
    @(posedge ref_clk);
    #1;
    req = {2'b00, ~a, ~d};
  endtask : cpu
  task automatic rdChk(input logic [7:0] a, e);
    cpu(1'b1, a, 8'h00);
    `CHK(rdData, e)
  endtask : rdChk
  task automatic sendJ1(input logic [7:0] d);
    poc_drop_model_i.send(KIND_J1, d);
  endtask : sendJ1
  task automatic tOh;
    for (int k = 1; k < 7; k++)
      poc_drop_model_i.send(pocKind_e'(k), {4'(k), 4'hF});
    for (int k = 1; k < 7; k++)
      rdChk(8'h79 + 8'(k), {4'(k), k == 1 ? 4'h8 : 4'hF});
    rdChk(OFS_RX_H4, 8'h3F);
    rdChk(OFS_RX_Z5, 8'h6F);
    cpu(1'b0, OFS_RX_F2, 8'h00);
    rdChk(OFS_RX_F2, 8'h2F);
    rdChk(8'h10, 8'h00);
    enPin = 1'b0;
    repeat (6) @(posedge ref_clk);
    poc_drop_model_i.send(KIND_F2, 8'h5A);
    enPin = 1'b1;
    repeat (6) @(posedge ref_clk);
    rdChk(OFS_RX_F2, 8'h2F);
    poc_drop_model_i.send(KIND_F2, 8'hA5);
    rdChk(OFS_RX_F2, 8'hA5);
  endtask : tOh
  task automatic tTrace(input logic s, input int n);
    logic [7:0] e [64];
    int len;
    len = s ? 16 : 64;
    lenSel = s;
    if (s && ptr > 15)
      ptr = 0;
    for (int i = 0; i < n; i++)
    begin
      sendJ1(8'(i + 1));
      e[ptr] = 8'(i + 1);
      ptr = (ptr + 1) % len;
    end
    for (int i = 0; i < len; i++)
      rdChk(OFS_RX_TRACE + 8'(i), e[i]);
  endtask : tTrace
  task automatic tAlign;
    for (int i = 0; i < 16; i++)
    begin
      msg[i] = i == 0 ? 8'h8A : 8'(8'h30 + i);
      cpu(1'b0, OFS_EXP_TRACE + 8'(i), msg[i]);
    end
    rdChk(OFS_EXP_TRACE + 8'h03, msg[3]);
    cmpEn = 1'b1;
    for (int i = 5; i < 96; i++)
      sendJ1(msg[i % 16]);
    repeat (3) @(posedge ref_clk);
    `CHK({lol, mis}, 2'b00)
    for (int i = 0; i < 16; i++)
      rdChk(OFS_RX_TRACE + 8'(i), msg[i]);
    cmpEn = 1'b0;
    cpu(1'b0, OFS_EXP_TRACE + 8'h03, 8'h55);
    cmpEn = 1'b1;
    for (int i = 0; i < 16; i++)
      sendJ1(msg[i]);
    repeat (3) @(posedge ref_clk);
    `CHK({lol, mis}, 2'b01)
    for (int i = 0; i < 16; i++)
      sendJ1(i == 7 ? msg[i] ^ 8'h01 : msg[i]);
    repeat (3) @(posedge ref_clk);
    `CHK(lol, 1'b1)
    rdChk(OFS_RX_TRACE + 8'h07, msg[7]);
  endtask : tAlign
  task automatic tallyAndFinish;
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tallyAndFinish
  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    enPin = 1'b1;
    lenSel = 1'b0;
    cmpEn = 1'b0;
    req = '0;
    errTotal = 0;
    nCompared = 0;
    ptr = 0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    tOh;
    tTrace(1'b0, 80);
    tTrace(1'b1, 20);
    tAlign;
    tallyAndFinish;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    tallyAndFinish;
  end
endmodule : poc_rx_path_overhead_capture_test
`default_nettype wire
